// [pcnt_params.svh]
`ifndef PCNT_PARAMS_SVH
`define PCNT_PARAMS_SVH
// Counter range
`define CNT_MAX       20'hF423F
// Clock and time base
`define CLK_PERIOD_PS 5000
`define US_PS         1000000
`define US_CYC        (`US_PS / `CLK_PERIOD_PS)
`define HOLD_S        2
`define HOLD_US       (`HOLD_S * 1000000)
`define IDLE_MIN      2
`define IDLE_US       (`IDLE_MIN * 60 * 1000000)
`define RATE_NUM      32'h000F4240
// Configuration limits
`define RATE_MIN      12'h001
`define RATE_MAX      12'h9C4
`define DEB_MIN       20'h000C8
`define DEB_MAX       20'hF423F
`define MUL_MIN       17'h00001
`define MUL_MAX       17'h1869F
`define FDP_MAX       3'h5
`define RECOVER_PW    16'h1098
// Parameter indices in the non-volatile store
`define P_SP          3'h0
`define P_MUL         3'h1
`define P_FDP         3'h2
`define P_DP          3'h3
`define P_MODE        3'h4
`define P_RATE        3'h5
`define P_DEB         3'h6
`define P_PW          3'h7
`define PW_SET_BIT    16
// Factory defaults
`define DF_MUL        24'h000001
`define DF_RATE       24'h0009C4
`define DF_DEB        24'h0000C8
// Register byte offsets
`define A_COUNT       8'h00
`define A_VALUE       8'h04
`define A_STATUS      8'h08
`define A_PASS        8'h0C
`define A_SEL         8'h10
`define A_EDIT        8'h14
`define A_LOCK        8'h18
`define A_PARAM       8'h1C
`define FACT_BIT      16
`endif

// [pcnt_pkg.sv]
`include "pcnt_params.svh"
package pcnt_pkg;
	// Load sequencer states
	typedef enum logic [1:0] {
		LD_READ = 2'b00,
		LD_FACT = 2'b01,
		LD_RUN  = 2'b10
	} ld_e;
	// Field pins
	typedef struct packed {
		logic cnt;
		logic start;
		logic rst;
		logic blk;
	} pins_s;
	// Front panel buttons
	typedef struct packed {
		logic prog;
		logic up;
		logic clr;
	} btns_s;
	// Indicator lamps
	typedef struct packed {
		logic key_lock;
		logic rst_on;
		logic blk_on;
		logic run;
		logic out;
	} leds_s;
	// Six-digit display content
	typedef struct packed {
		logic [19:0] value;
		logic [2:0]  dp;
		logic [2:0]  sel;
		logic        setup;
		logic        edit;
		logic        prompt;
	} disp_s;
	// Whole state of the counter
	typedef struct packed {
		logic [19:0]       cnt, val, sp, el, deb;
		logic [16:0]       mul;
		logic [2:0]        multiplier_decimals, dp, sel, nv_wa;
		logic              mode, pw_set, run, outq, setup, edit, unlock;
		logic              klock, splock, hold_done, cin_d, ack;
		logic [11:0]       rate;
		logic [15:0]       pw;
		logic [26:0]       hold, idle;
		logic [7:0]        us;
		logic [6:0]        s1, s2;
		logic [5:0]        db, db_d;
		logic [5:0][19:0]  dbt;
		logic [23:0]       ev, nv_wd;
		ld_e               ld;
		logic [3:0]        idx;
		logic [31:0]       dat;
		logic              nv_we;
	} state_s;
	// Factory default of one parameter
	function automatic logic [23:0] dflt(input logic [2:0] i);
		case (i)
			`P_MUL:  dflt = `DF_MUL;
			`P_RATE: dflt = `DF_RATE;
			`P_DEB:  dflt = `DF_DEB;
			default: dflt = 24'h000000;
		endcase
	endfunction
endpackage

// [nv_store.sv]
`include "pcnt_params.svh"
module nv_store import pcnt_pkg::*; #(
	parameter int W = 24,
	parameter int D = 8,
	parameter int AW = 3
) (
	input  wire logic          clk,   // System clock
	input  wire logic          we,    // Write strobe
	input  wire logic [AW-1:0] wa,    // Write index
	input  wire logic [W-1:0]  wd,    // Write data
	input  wire logic [AW-1:0] ra,    // Read index
	output logic      [W-1:0]  rd     // Registered read data
);
	logic [W-1:0] mem [D];  // Retained words, no reset on purpose

	// Stands for factory-programmed content at first power-up
	initial begin
		for (int i = 0; i < D; i++) begin
			mem[i] = W'(dflt(3'(i)));
		end
	end

	////////////////////////////////////////////////////////////////
	// Write port and registered read
	always_ff @(posedge clk) begin
		if (we) begin
			mem[wa] <= wd;
		end
		rd <= mem[ra];
	end
endmodule

// [pulse_counter.sv]
// Functional notes
// - Accepted pulses increment count by one
// - Past 999999 count wraps to zero
// - Start/stop pulses toggle counting on/off
// - Active reset input holds count zero
// - Active block input suppresses counting pulses
// - Scale count by multiplier, round upward
// - Setpoint compared against scaled value
// - Counting input limited to configured rate
// - Control inputs debounced by configured time
// - Program held two seconds toggles setup
// - Two idle minutes abandon editing
// - First setup asks new password, then enforces
// - Recovery password 1098 always unlocks setup
// - Confirmed values written to non-volatile store
// - Display decimals never exceed multiplier decimals
// - Clear button clears count or restores edit
// - Display shows scaled value or selected parameter
// - Lamps for lock, reset, block, run, output
// - Up button edits setpoint unless locked
// - Program button enters, exits, commits edits
// - Mode 1: output when value reaches setpoint
// - Mode 2: output below setpoint while running
`include "pcnt_params.svh"
module pulse_counter import pcnt_pkg::*; #(
	parameter int HOLD_US = `HOLD_US,
	parameter int IDLE_US = `IDLE_US,
	parameter int US_CYC  = `US_CYC   // Clock cycles per microsecond tick
) (
	input  wire logic        clk,       // 200 MHz clock
	input  wire logic        rst_b,     // Async reset, active low
	input  wire pins_s       pins,      // Counting and control inputs
	input  wire btns_s       btns,      // Front panel buttons, high = pressed
	input  wire logic        wb_cyc_i,  // Wishbone cycle
	input  wire logic        wb_stb_i,  // Wishbone strobe
	input  wire logic        wb_we_i,   // Wishbone write
	input  wire logic [7:0]  wb_adr_i,  // Wishbone byte address
	input  wire logic [3:0]  wb_sel_i,  // Wishbone byte enables
	input  wire logic [31:0] wb_dat_i,  // Wishbone write data
	output logic      [31:0] wb_dat_o,  // Wishbone read data
	output logic             wb_ack_o,  // Wishbone acknowledge
	output logic             out_q,     // Switching output
	output leds_s            leds,      // Indicator lamps
	output disp_s            disp       // Display content
);
	state_s      s_r;      // Registered state
	state_s      s_nxt;    // Next state
	logic [23:0] nv_rd;    // Store read data
	logic [2:0]  nv_ra;    // Store read index

	////////////////////////////////////////////////////////////////
	// Retained parameter store
	nv_store #(.W(24), .D(8), .AW(3)) u_nv (
		.clk (clk),
		.we  (s_r.nv_we),
		.wa  (s_r.nv_wa),
		.wd  (s_r.nv_wd),
		.ra  (nv_ra),
		.rd  (nv_rd)
	);

	assign nv_ra = s_r.idx[2:0];

	// Working value of one parameter
	function automatic logic [23:0] pget(input state_s s, input logic [2:0] i);
		case (i)
			`P_SP:   pget = {4'h0, s.sp};
			`P_MUL:  pget = {7'h00, s.mul};
			`P_FDP:  pget = {21'h000000, s.multiplier_decimals};
			`P_DP:   pget = {21'h000000, s.dp};
			`P_MODE: pget = {23'h000000, s.mode};
			`P_RATE: pget = {12'h000, s.rate};
			`P_DEB:  pget = {4'h0, s.deb};
			default: pget = {7'h00, s.pw_set, s.pw};
		endcase
	endfunction

	// Apply one parameter value to the working copy
	function automatic state_s put(input state_s s, input logic [2:0] i,
			input logic [23:0] v);
		state_s r;
		r = s;
		case (i)
			`P_SP:   r.sp = v[19:0];
			`P_MUL:  r.mul = v[16:0];
			`P_FDP:  r.multiplier_decimals = v[2:0];
			`P_DP:   r.dp = v[2:0];
			`P_MODE: r.mode = v[0];
			`P_RATE: r.rate = v[11:0];
			`P_DEB:  r.deb = v[19:0];
			default: begin
				r.pw = v[15:0];
				r.pw_set = v[`PW_SET_BIT];
			end
		endcase
		put = r;
	endfunction

	// Range check on commit; decimals may not cross each other
	function automatic logic valid(input state_s s, input logic [2:0] i,
			input logic [23:0] v);
		case (i)
			`P_SP:   valid = v <= {4'h0, `CNT_MAX};
			`P_MUL:  valid = v >= {7'h00, `MUL_MIN} && v <= {7'h00, `MUL_MAX};
			`P_FDP:  valid = v <= {21'h0, `FDP_MAX} && v >= {21'h0, s.dp};
			`P_DP:   valid = v <= {21'h0, s.multiplier_decimals};
			`P_MODE: valid = v <= 24'h000001;
			`P_RATE: valid = v >= {12'h000, `RATE_MIN} && v <= {12'h000, `RATE_MAX};
			`P_DEB:  valid = v >= {4'h0, `DEB_MIN} && v <= {4'h0, `DEB_MAX};
			default: valid = 1'b0;
		endcase
	endfunction

	// Byte-lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
			input logic [3:0] m);
		for (int b = 0; b < 4; b++) begin
			merge[8*b +: 8] = m[b] ? d[8*b +: 8] : o[8*b +: 8];
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		logic        tick;
		logic [5:0]  rise;
		logic [5:0]  fall;
		logic        accept;
		logic        clr_cnt;
		logic        ptap;
		logic [2:0]  k;
		logic [39:0] prod;
		logic [39:0] q;
		logic        wr;
		logic        pass_ok;
		logic [31:0] wd;
		tick = 1'b0;
		rise = '0;
		fall = '0;
		accept = 1'b0;
		clr_cnt = 1'b0;
		ptap = 1'b0;
		k = '0;
		prod = '0;
		q = '0;
		wr = 1'b0;
		pass_ok = 1'b0;
		wd = '0;
		s_nxt = s_r;
		s_nxt.nv_we = 1'b0;

		// Two-stage synchronisers; only stage two is looked at
		s_nxt.s1 = {pins.cnt, btns.clr, btns.up, btns.prog, pins.blk, pins.rst,
			pins.start};
		s_nxt.s2 = s_r.s1;

		// Microsecond time base
		tick = (s_r.us == 8'(US_CYC - 1));
		s_nxt.us = tick ? 8'h00 : s_r.us + 8'h01;

		// Debounce: a new level must hold for the set time before it counts
		for (int i = 0; i < 6; i++) begin
			if (s_r.s2[i] == s_r.db[i]) begin
				s_nxt.dbt[i] = 20'h00000;
			end else if (s_r.dbt[i] >= s_r.deb) begin
				s_nxt.db[i] = s_r.s2[i];
				s_nxt.dbt[i] = 20'h00000;
			end else if (tick) begin
				s_nxt.dbt[i] = s_r.dbt[i] + 20'h00001;
			end
		end
		s_nxt.db_d = s_r.db;
		rise = s_r.db & ~s_r.db_d;
		fall = ~s_r.db & s_r.db_d;

		// Rate filter: an edge is taken only once 1/rate has elapsed
		s_nxt.cin_d = s_r.s2[6];
		if (tick && s_r.el < `RATE_NUM) begin
			s_nxt.el = s_r.el + 20'h00001;
		end
		accept = s_r.s2[6] && !s_r.cin_d &&
			(32'(s_r.el) * 32'(s_r.rate) >= `RATE_NUM);
		if (accept) begin
			s_nxt.el = 20'h00000;
		end

		// Start/stop toggles the run state
		if (rise[0]) begin
			s_nxt.run = ~s_r.run;
		end

		// Program button: long hold toggles setup, short press acts on release
		if (s_r.db[3]) begin
			if (tick && !s_r.hold_done) begin
				s_nxt.hold = s_r.hold + 27'h0000001;
			end
			if (s_r.hold >= 27'(HOLD_US) && !s_r.hold_done) begin
				s_nxt.hold_done = 1'b1;
				s_nxt.setup = ~s_r.setup;
				s_nxt.edit = 1'b0;
				s_nxt.unlock = 1'b0;
				s_nxt.sel = `P_SP;
			end
		end else begin
			s_nxt.hold = '0;
			s_nxt.hold_done = 1'b0;
		end
		ptap = fall[3] && !s_r.hold_done;

		if (s_r.edit) begin
			// Inactivity watchdog while editing
			if (|rise) begin
				s_nxt.idle = '0;
			end else if (tick) begin
				s_nxt.idle = s_r.idle + 27'h0000001;
			end
			if (s_r.idle >= 27'(IDLE_US)) begin
				s_nxt.edit = 1'b0;
			end
			if (rise[5]) begin
				s_nxt.ev = pget(s_r, s_r.sel);
			end
			if (ptap) begin
				// A value out of range is dropped, the old one stays
				s_nxt.edit = 1'b0;
				if (valid(s_r, s_r.sel, s_r.ev)) begin
					s_nxt = put(s_nxt, s_r.sel, s_r.ev);
					s_nxt.nv_we = 1'b1;
					s_nxt.nv_wa = s_r.sel;
					s_nxt.nv_wd = s_r.ev;
				end
			end
		end else if (s_r.setup) begin
			if (ptap && s_r.unlock) begin
				s_nxt.edit = 1'b1;
				s_nxt.idle = '0;
				s_nxt.ev = pget(s_r, s_r.sel);
			end
			if (rise[4]) begin
				s_nxt.sel = (s_r.sel == `P_DEB) ? `P_SP : s_r.sel + 3'h1;
			end
		end else if (!s_r.klock) begin
			if (rise[4] && !s_r.splock) begin
				s_nxt.edit = 1'b1;
				s_nxt.idle = '0;
				s_nxt.sel = `P_SP;
				s_nxt.ev = {4'h0, s_r.sp};
			end
			clr_cnt = rise[5];
		end

		// Count register; reset input dominates, block input gates pulses
		if (s_r.db[1] || clr_cnt) begin
			s_nxt.cnt = 20'h00000;
		end else if (accept && s_r.run && !s_r.db[2]) begin
			s_nxt.cnt = (s_r.cnt == `CNT_MAX) ? 20'h00000 :
				s_r.cnt + 20'h00001;
		end

		// Scaling with upward rounding; shows saturate at six digits
		prod = 40'(s_r.cnt) * 40'(s_r.mul);
		k = s_r.multiplier_decimals - s_r.dp;
		case (k)
			3'h1:    q = (prod + 40'h0000000009) / 40'h000000000A;
			3'h2:    q = (prod + 40'h0000000063) / 40'h0000000064;
			3'h3:    q = (prod + 40'h00000003E7) / 40'h00000003E8;
			3'h4:    q = (prod + 40'h000000270F) / 40'h0000002710;
			3'h5:    q = (prod + 40'h000001869F) / 40'h00000186A0;
			default: q = prod;
		endcase
		s_nxt.val = (q > 40'(`CNT_MAX)) ? `CNT_MAX : q[19:0];

		// Output against setpoint at display resolution
		if (!s_r.mode) begin
			s_nxt.outq = s_r.val >= s_r.sp;
		end else begin
			s_nxt.outq = s_r.run && s_r.val < s_r.sp;
		end

		// Wishbone slave, one wait state, ack dropped after one cycle
		s_nxt.ack = wb_cyc_i && wb_stb_i && !s_r.ack;
		// A write lands on the edge at which the master samples ack high
		wr = wb_cyc_i && wb_stb_i && wb_we_i && s_r.ack;
		wd = wb_dat_i;
		pass_ok = (wd[15:0] == s_r.pw) || (wd[15:0] == `RECOVER_PW);
		case (wb_adr_i)
			`A_COUNT:  s_nxt.dat = {12'h000, s_r.cnt};
			`A_VALUE:  s_nxt.dat = {12'h000, s_r.val};
			`A_STATUS: s_nxt.dat = {22'h000000, s_r.ld == LD_RUN, !s_r.pw_set,
				s_r.unlock, s_r.edit, s_r.setup, s_r.db[2], s_r.db[1], s_r.outq,
				s_r.run, s_r.klock};
			`A_SEL:    s_nxt.dat = {29'h00000000, s_r.sel};
			`A_EDIT:   s_nxt.dat = {8'h00, s_r.ev};
			`A_LOCK:   s_nxt.dat = {30'h00000000, s_r.splock, s_r.klock};
			`A_PARAM:  s_nxt.dat = {8'h00, pget(s_r, s_r.sel)};
			default:   s_nxt.dat = 32'h00000000;
		endcase
		if (wr) begin
			case (wb_adr_i)
				`A_PASS: begin
					if (s_r.setup && !s_r.edit && wb_sel_i[1:0] == 2'h3) begin
						if (!s_r.pw_set) begin
							// First entry: take the new password and unlock
							s_nxt.pw = wd[15:0];
							s_nxt.pw_set = 1'b1;
							s_nxt.unlock = 1'b1;
							s_nxt.nv_we = 1'b1;
							s_nxt.nv_wa = `P_PW;
							s_nxt.nv_wd = {7'h00, 1'b1, wd[15:0]};
						end else begin
							s_nxt.unlock = pass_ok;
							if (pass_ok && wb_sel_i[2] && wd[`FACT_BIT]) begin
								s_nxt.ld = LD_FACT;
								s_nxt.idx = 4'h0;
							end
						end
					end
				end
				`A_SEL: begin
					if (s_r.setup && !s_r.edit && wb_sel_i[0]) begin
						s_nxt.sel = wd[2:0];
					end
				end
				`A_EDIT: begin
					if (s_r.edit) begin
						s_nxt.ev = 24'(merge({8'h00, s_r.ev}, wd, wb_sel_i));
						s_nxt.idle = '0;
					end
				end
				`A_LOCK: begin
					if (wb_sel_i[0]) begin
						s_nxt.klock = wd[0];
						s_nxt.splock = wd[1];
					end
				end
				default: begin
				end
			endcase
		end

		// Load after reset, or factory restore; both walk all eight words
		case (s_r.ld)
			LD_READ: begin
				if (s_r.idx != 4'h0) begin
					s_nxt = put(s_nxt, 3'(s_r.idx - 4'h1), nv_rd);
				end
				s_nxt.idx = s_r.idx + 4'h1;
				if (s_r.idx == 4'h8) begin
					s_nxt.ld = LD_RUN;
					s_nxt.idx = 4'h0;
				end
			end
			LD_FACT: begin
				s_nxt = put(s_nxt, s_r.idx[2:0], dflt(s_r.idx[2:0]));
				s_nxt.nv_we = 1'b1;
				s_nxt.nv_wa = s_r.idx[2:0];
				s_nxt.nv_wd = dflt(s_r.idx[2:0]);
				s_nxt.idx = s_r.idx + 4'h1;
				if (s_r.idx == 4'h7) begin
					s_nxt.ld = LD_RUN;
					s_nxt.idx = 4'h0;
					s_nxt.unlock = 1'b0;
				end
			end
			LD_RUN: begin
				s_nxt.idx = 4'h0;
			end
			default: begin
				s_nxt.ld = LD_RUN;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// State register; all zero, then load sequencer fills the settings
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs
	assign wb_dat_o = s_r.dat;
	assign wb_ack_o = s_r.ack;
	assign out_q = s_r.outq;
	assign leds = '{key_lock: s_r.klock, rst_on: s_r.db[1], blk_on: s_r.db[2],
		run: s_r.run, out: s_r.outq};
	// Edit buffer while editing, else parameter in setup or scaled value in operation
	assign disp = '{value: s_r.edit ? s_r.ev[19:0] :
		(s_r.setup ? 20'(pget(s_r, s_r.sel)) : s_r.val),
		dp: s_r.dp, sel: s_r.sel, setup: s_r.setup, edit: s_r.edit,
		prompt: s_r.setup && !s_r.pw_set};
endmodule

// [pulse_counter_asserts.sv]
`include "pcnt_params.svh"
module pulse_counter_asserts import pcnt_pkg::*; #(
	parameter int HOLD_US = 20,
	parameter int IDLE_US = 50,
	parameter int US_CYC  = 200
) (
	input wire logic        clk,      // Clock
	input wire logic        rst_b,    // Reset, active low
	input wire pins_s       pins,     // Field inputs
	input wire btns_s       btns,     // Buttons
	input wire logic        wb_cyc_i, // Bus cycle
	input wire logic        wb_stb_i, // Bus strobe
	input wire logic        wb_we_i,  // Bus write
	input wire logic [7:0]  wb_adr_i, // Bus address
	input wire logic [3:0]  wb_sel_i, // Byte enables
	input wire logic [31:0] wb_dat_i, // Write data
	input wire logic [31:0] wb_dat_o, // Read data
	input wire logic        wb_ack_o, // Acknowledge
	input wire logic        out_q,    // Switching output
	input wire leds_s       leds,     // Lamps
	input wire disp_s       disp      // Display
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HOLD_CYC = HOLD_US * US_CYC; // Cycles of the full hold
	logic [31:0] held_r; // Length of the latest program press
	logic        prog_r; // Program button one cycle back
	////////////////////////////////////////////////////////////////////////////////
	// Press length is kept after release, so a toggle on release is judged too
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			held_r <= '0;
			prog_r <= 1'b0;
		end else begin
			prog_r <= btns.prog;
			if (btns.prog)
				held_r <= prog_r ? held_r + 32'h1 : 32'h1;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// A request the slave has not yet answered
	sequence bus_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// Answer to a read of one address
	sequence rd_of(logic [7:0] a);
		wb_ack_o && !wb_we_i && wb_adr_i == a;
	endsequence
	chk_ack_next: assert property (bus_take |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	chk_count_range: assert property (rd_of(`A_COUNT) |-> wb_dat_o <= 32'h000F423F)
		else $error("count above its maximum");
	// Status word was captured one edge before ack is seen
	chk_run_status: assert property (rd_of(`A_STATUS) |-> wb_dat_o[1] == $past(leds.run))
		else $error("run lamp and status disagree");
	chk_lamp_out: assert property ($rose(out_q) |-> ##[0:1] leds.out)
		else $error("output lamp not lit");
	chk_reset_zero: assert property ((leds.rst_on && !disp.setup) [*4] |->
		disp.value == 20'h00000) else $error("count not cleared by reset input");
	chk_block_hold: assert property ((leds.blk_on && !leds.rst_on && !disp.setup) [*4] |=>
		$stable(disp.value) || disp.setup || leds.rst_on) else $error("count moved while blocked");
	chk_hold_toggle: assert property ($changed(disp.setup) |-> held_r >= HOLD_CYC)
		else $error("setup toggled without a long press");
	// Quiet line before the edge, so an earlier bounce cannot move the value
	chk_sync_lag: assert property ($rose(pins.cnt) && !$past(pins.cnt, 2) &&
		!$past(pins.cnt, 3) && !leds.rst_on && !disp.setup |=> $stable(disp.value) [*2])
		else $error("count reacted before synchronising");
endmodule

// [field_side.sv]
module field_side import pcnt_pkg::*; (
	input  wire logic  clk,       // Clock
	input  wire pins_s want_pins, // Wanted field levels
	input  wire btns_s want_btns, // Wanted button levels
	output pins_s      pins,      // Field inputs as the contacts give them
	output btns_s      btns       // Buttons as the contacts give them
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [6:0] want;                          // All wanted levels
	logic [6:0] lvl = '0;                      // Contact levels
	logic [6:0] tgt = '0;                      // Level each contact settles to
	logic [2:0] chat [7] = '{default: 3'h0};   // Bounce cycles left per contact
	assign want = {want_pins, want_btns};
	assign {pins, btns} = lvl;
	////////////////////////////////////////////////////////////////////////////////
	// Every change chatters five cycles, so filters never see a clean edge
	always @(posedge clk) begin
		for (int i = 0; i < 7; i++) begin
			if (want[i] != tgt[i]) begin
				tgt[i] = want[i];
				chat[i] = 3'h5;
			end
			if (chat[i] != 3'h0) begin
				lvl[i] <= ~lvl[i];
				chat[i] = chat[i] - 3'h1;
			end else
				lvl[i] <= tgt[i];
		end
	end
endmodule

// [tb_pulse_counter.sv]
`include "pcnt_params.svh"
module tb_pulse_counter import pcnt_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int US_CYC  = 2;     // Fast time base keeps the run brief
	localparam int HOLD_US = 600;   // Hold outlasts a debounced short press
	localparam int IDLE_US = 2000;  // Idle limit outlasts a short press
	localparam int DEB_CYC = 500;   // 200 us debounce plus margin
	localparam int GAP_CYC = 900;   // 400 us pulse spacing at 2500 Hz plus margin
	logic        clk, rst_b, cyc, stb, we; // Clock, reset, bus strobes
	logic [7:0]  adr;                      // Bus address
	logic [3:0]  sel;                      // Byte enables
	logic [31:0] dat_w, dat_r;             // Bus data
	logic        ack, out_q;               // Acknowledge, output
	pins_s       want_pins, pins;          // Field levels
	btns_s       want_btns, btns;          // Button levels
	leds_s       leds;                     // Lamps
	disp_s       disp;                     // Display
	int          n_errors, cmp_count;      // Verdict counters
	pulse_counter #(.HOLD_US(HOLD_US), .IDLE_US(IDLE_US), .US_CYC(US_CYC)) dut (.clk(clk),
		.rst_b(rst_b), .pins(pins), .btns(btns), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
		.out_q(out_q), .leds(leds), .disp(disp));
	field_side side (.clk(clk), .want_pins(want_pins), .want_btns(want_btns), .pins(pins),
		.btns(btns));
	////////////////////////////////////////////////////////////////////////////////
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One classic cycle; waits for ack however long it takes, up to a limit
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clk);
		{cyc, stb, we, adr, dat_w, sel} <= {2'b11, w, a, d, 4'hF};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = dat_r;
		check({31'h0, ack}, 32'h1);
		{cyc, stb, we} <= 3'b000;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic drive(input pins_s p, input btns_s b);
		@(posedge clk);
		want_pins <= p;
		want_btns <= b;
	endtask
	task automatic pulse;
		@(posedge clk);
		want_pins.cnt <= 1'b1;
		wait_cyc(30);
		want_pins.cnt <= 1'b0;
		wait_cyc(30);
	endtask
	task automatic count_is(input logic [31:0] exp);
		logic [31:0] q;
		rd(`A_COUNT, q);
		check(q, exp);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Status after load, unmapped and read-only places, lock lamp
	task automatic s_bus;
		logic [31:0] q;
		rd(`A_STATUS, q);
		check(q & 32'h2FF, 32'h204);
		check({31'h0, out_q}, 32'h1);
		rd(8'h40, q);
		check(q, 32'h0);
		wr(`A_COUNT, 32'h1234);
		count_is(32'h0);
		wr(`A_LOCK, 32'h3);
		rd(`A_LOCK, q);
		check(q & 32'h3, 32'h3);
		check({31'h0, leds.key_lock}, 32'h1);
		wr(`A_LOCK, 32'h0);
	endtask
	// Stopped pulse ignored, start toggles on rising only, rate limit, scaling
	task automatic s_count;
		logic [31:0] q;
		wait_cyc(GAP_CYC); // Rate limit open, so only the stopped state refuses
		pulse;
		count_is(32'h0);
		drive(4'b0100, 3'b000);
		wait_cyc(DEB_CYC);
		check({31'h0, leds.run}, 32'h1);
		drive(4'b0000, 3'b000);
		wait_cyc(DEB_CYC + 400);
		check({31'h0, leds.run}, 32'h1);
		pulse;
		count_is(32'h1);
		pulse;
		count_is(32'h1);
		wait_cyc(GAP_CYC);
		pulse;
		count_is(32'h2);
		rd(`A_VALUE, q);
		check(q, 32'h2);
	endtask
	// Block input suppresses an otherwise valid pulse
	task automatic s_block;
		drive(4'b0001, 3'b000);
		wait_cyc(DEB_CYC);
		check({31'h0, leds.blk_on}, 32'h1);
		wait_cyc(GAP_CYC - DEB_CYC);
		pulse;
		count_is(32'h2);
		drive(4'b0000, 3'b000);
		wait_cyc(DEB_CYC);
	endtask
	// Short reset glitch filtered out, long one clears the count
	task automatic s_rst;
		drive(4'b0010, 3'b000);
		wait_cyc(100);
		drive(4'b0000, 3'b000);
		wait_cyc(200);
		count_is(32'h2);
		drive(4'b0010, 3'b000);
		wait_cyc(DEB_CYC);
		check({31'h0, leds.rst_on}, 32'h1);
		count_is(32'h0);
		check({12'h0, disp.value}, 32'h0);
		drive(4'b0000, 3'b000);
		wait_cyc(DEB_CYC);
	endtask
	// Long program press; setup must not start before the hold has run out
	task automatic enter;
		drive(4'b0000, 3'b100);
		wait_cyc(DEB_CYC);
		check({31'h0, disp.setup}, 32'h0);
		wait_cyc(HOLD_US * US_CYC + 300);
		drive(4'b0000, 3'b000);
		wait_cyc(DEB_CYC);
		check({31'h0, disp.setup}, 32'h1);
	endtask
	task automatic unlocked_is(input logic exp);
		logic [31:0] q;
		rd(`A_STATUS, q);
		check({31'h0, q[7]}, {31'h0, exp});
	endtask
	// First entry sets the password; after a reset it is enforced, recovery works
	task automatic s_setup;
		enter;
		check({31'h0, disp.prompt}, 32'h1);
		wr(`A_PASS, 32'h1234);
		unlocked_is(1'b1);
		rst_b <= 1'b0;
		wait_cyc(20);
		rst_b <= 1'b1;
		wait_cyc(12);
		enter;
		check({31'h0, disp.prompt}, 32'h0);
		wr(`A_PASS, 32'h5555);
		unlocked_is(1'b0);
		wr(`A_PASS, 32'h1098);
		unlocked_is(1'b1);
	endtask
	// Short program press, released well before the hold runs out
	task automatic tap;
		drive(4'b0000, 3'b100);
		wait_cyc(DEB_CYC);
		drive(4'b0000, 3'b000);
		wait_cyc(DEB_CYC);
	endtask
	// Select, open, fill and commit one parameter
	task automatic set_param(input logic [2:0] i, input logic [23:0] v);
		wr(`A_SEL, {29'h0, i});
		tap;
		wr(`A_EDIT, {8'h0, v});
		tap;
	endtask
	// Decimals raised in the advised order, a crossing value refused, dispenser mode
	task automatic s_edit;
		logic [31:0] q;
		set_param(`P_FDP, 24'h1);
		set_param(`P_DP, 24'h1);
		check({29'h0, disp.dp}, 32'h1);
		set_param(`P_FDP, 24'h0);
		rd(`A_PARAM, q);
		check(q, 32'h1);
		wr(`A_SEL, {29'h0, `P_DP});
		rd(`A_PARAM, q);
		check(q, 32'h1);
		set_param(`P_MODE, 24'h1);
		check({31'h0, out_q}, 32'h0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		if (n_errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Free-running 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Main sequence
	initial begin
		{rst_b, cyc, stb, we, adr, sel, dat_w} = '0;
		want_pins = '0;
		want_btns = '0;
		n_errors = 0;
		cmp_count = 0;
		wait_cyc(20);
		rst_b <= 1'b1;
		wait_cyc(12);
		s_bus;
		s_count;
		s_block;
		s_rst;
		s_setup;
		s_edit;
		tally_and_finish;
	end
	// Watchdog well beyond the expected run of about 20k cycles
	initial begin
		wait_cyc(40000);
		n_errors++;
		tally_and_finish;
	end
endmodule
bind pulse_counter pulse_counter_asserts #(.HOLD_US(HOLD_US), .IDLE_US(IDLE_US),
	.US_CYC(US_CYC)) chk (
	.clk(clk), .rst_b(rst_b), .pins(pins), .btns(btns), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .out_q(out_q),
	.leds(leds), .disp(disp));
